/* src/pld_pkg.sv */
package pld_pkg;

  // Blink rate and system clock
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned BLINK_PER_SEC  = 4;
  // Half period of a 4 Hz blink in cycles (on and off phases equal)
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (BLINK_PER_SEC * 2);

  // Link speed codes reported by the link logic
  localparam logic [2:0] SPEED_10   = 3'h0;
  localparam logic [2:0] SPEED_100  = 3'h1;
  localparam logic [2:0] SPEED_1000 = 3'h2;
  localparam logic [2:0] SPEED_2500 = 3'h3;

  // Port kinds
  localparam logic [1:0] KIND_COPPER    = 2'h0;
  localparam logic [1:0] KIND_FIBRE_1G  = 2'h1;
  localparam logic [1:0] KIND_FIBRE_25G = 2'h2;

  // PoE powered device standard and signature
  localparam logic [1:0] PD_NONE = 2'h0;
  localparam logic [1:0] PD_AFAT = 2'h1;
  localparam logic [1:0] PD_BT   = 2'h2;

  // Class ranges
  localparam logic [3:0] SS_STD_MAX = 4'h4;
  localparam logic [3:0] SS_HP_MIN  = 4'h5;
  localparam logic [3:0] SS_HP_MAX  = 4'h8;
  localparam logic [3:0] DS_HP_MIN  = 4'h1;
  localparam logic [3:0] DS_HP_MAX  = 4'h5;

endpackage : pld_pkg

/* src/pld_led_driver.sv */
`timescale 1ns/1ps

module pld_led_driver
  import pld_pkg::*;
#(
  parameter int unsigned NUM_PORTS = 12,
  parameter int unsigned NUM_POE   = 8,
  parameter int unsigned HALF_CYC  = BLINK_HALF_CYC
) (
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic [NUM_PORTS*2-1:0] port_kind,
  input  wire logic [NUM_PORTS-1:0]   port_active,
  input  wire logic [NUM_PORTS-1:0]   link_up,
  input  wire logic [NUM_PORTS*3-1:0] link_speed,
  input  wire logic [NUM_PORTS-1:0]   tx_active,
  input  wire logic [NUM_POE*2-1:0]   pd_type,
  input  wire logic [NUM_POE-1:0]     pd_dual_sig,
  input  wire logic [NUM_POE*4-1:0]   pd_class,
  input  wire logic [NUM_POE-1:0]     pd_powered,
  input  wire logic [NUM_POE-1:0]     budget_shutoff,
  input  wire logic [NUM_POE-1:0]     detect_fail,
  input  wire logic [NUM_POE-1:0]     overcurrent,
  output logic      [NUM_PORTS-1:0]   led_green_q,
  output logic      [NUM_PORTS-1:0]   led_amber_q,
  output logic      [NUM_POE-1:0]     led_poe_hp_q,
  output logic      [NUM_POE-1:0]     led_poe_std_q,
  output logic      [NUM_POE-1:0]     led_poe_fault_q
);

  localparam int unsigned CW = $clog2(HALF_CYC + 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(HALF_CYC - 1);

  logic [CW-1:0] div_q;
  logic [CW-1:0] div_d;
  logic          wrap;
  logic          blink_q;
  logic          blink_d;

  assign wrap = (div_q == HALF_LAST);

  // Free-running half-period counter
  always_comb begin
    if (wrap) begin
      div_d = '0;
    end else begin
      div_d = div_q + CW'(1);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // Shared blink phase so all LEDs stay in step
  assign blink_d = wrap ? ~blink_q : blink_q;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      blink_q <= 1'b0;
    end else begin
      blink_q <= blink_d;
    end
  end

  // Pattern one LED shows
  typedef enum logic [1:0] {
    PAT_OFF,
    PAT_ON,
    PAT_BLINK
  } pld_pat_e;

  // Level of an LED for its pattern and the shared blink phase
  function automatic logic pat_level(pld_pat_e pat, logic phase);
    logic lvl;
    lvl = 1'b0;
    unique case (pat)
      PAT_OFF:   lvl = 1'b0;
      PAT_ON:    lvl = 1'b1;
      PAT_BLINK: lvl = phase;
      default:   lvl = 1'b0;
    endcase
    return lvl;
  endfunction : pat_level

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      logic [1:0] kind;
      logic [2:0] spd;
      logic       up;
      logic       spd_10;
      logic       spd_100;
      logic       spd_1000;
      logic       spd_2500;
      logic       use_green;
      logic       use_amber;
      pld_pat_e   green_pat;
      pld_pat_e   amber_pat;
      logic       green_d;
      logic       amber_d;

      assign kind     = port_kind[p*2 +: 2];
      assign spd      = link_speed[p*3 +: 3];
      assign up       = port_active[p] & link_up[p];
      assign spd_10   = (spd == SPEED_10);
      assign spd_100  = (spd == SPEED_100);
      assign spd_1000 = (spd == SPEED_1000);
      assign spd_2500 = (spd == SPEED_2500);

      // Speed LED that the port kind uses at the current speed
      always_comb begin
        use_green = 1'b0;
        use_amber = 1'b0;
        unique case (kind)
          KIND_COPPER: begin
            use_green = spd_1000;
            use_amber = spd_10 | spd_100;
          end
          KIND_FIBRE_1G: begin
            use_green = spd_1000;
            use_amber = spd_100;
          end
          KIND_FIBRE_25G: begin
            use_green = spd_2500;
            use_amber = spd_1000;
          end
          default: begin
            use_green = 1'b0;
            use_amber = 1'b0;
          end
        endcase
      end

      // Steady while linked, blinking while transmitting
      always_comb begin
        if (!up || !use_green) begin
          green_pat = PAT_OFF;
        end else if (tx_active[p]) begin
          green_pat = PAT_BLINK;
        end else begin
          green_pat = PAT_ON;
        end
      end

      always_comb begin
        if (!up || !use_amber) begin
          amber_pat = PAT_OFF;
        end else if (tx_active[p]) begin
          amber_pat = PAT_BLINK;
        end else begin
          amber_pat = PAT_ON;
        end
      end

      assign green_d = pat_level(green_pat, blink_q);
      assign amber_d = pat_level(amber_pat, blink_q);

      // Registered so the pins never glitch
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          led_green_q[p] <= 1'b0;
        end else begin
          led_green_q[p] <= green_d;
        end
      end

      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          led_amber_q[p] <= 1'b0;
        end else begin
          led_amber_q[p] <= amber_d;
        end
      end
    end

    for (p = 0; p < NUM_POE; p++) begin : g_poe
      logic [1:0] typ;
      logic [3:0] cls;
      logic       is_bt;
      logic       is_afat;
      logic       ss_std_cls;
      logic       ss_hp_cls;
      logic       ds_hp_cls;
      logic       hp_ok;
      logic       std_ok;
      pld_pat_e   hp_pat;
      pld_pat_e   std_pat;
      pld_pat_e   fault_pat;
      logic       hp_d;
      logic       std_d;
      logic       fault_d;

      assign typ     = pd_type[p*2 +: 2];
      assign cls     = pd_class[p*4 +: 4];
      assign is_bt   = (typ == PD_BT);
      assign is_afat = (typ == PD_AFAT);

      // Class windows for each signature kind
      always_comb begin
        ss_std_cls = 1'b0;
        ss_hp_cls  = 1'b0;
        ds_hp_cls  = 1'b0;
        if (cls <= SS_STD_MAX) begin
          ss_std_cls = 1'b1;
        end
        if (cls >= SS_HP_MIN && cls <= SS_HP_MAX) begin
          ss_hp_cls = 1'b1;
        end
        if (cls >= DS_HP_MIN && cls <= DS_HP_MAX) begin
          ds_hp_cls = 1'b1;
        end
      end

      // Power delivered to a recognised device in its class window
      always_comb begin
        hp_ok  = 1'b0;
        std_ok = 1'b0;
        if (pd_powered[p]) begin
          if (pd_dual_sig[p]) begin
            hp_ok = is_bt && ds_hp_cls;
          end else begin
            hp_ok  = is_bt && ss_hp_cls;
            std_ok = is_afat && ss_std_cls;
          end
        end
      end

      always_comb begin
        if (hp_ok) begin
          hp_pat = PAT_ON;
        end else begin
          hp_pat = PAT_OFF;
        end
      end

      // Budget shutoff overrides the steady indication
      always_comb begin
        if (budget_shutoff[p]) begin
          std_pat = PAT_BLINK;
        end else if (std_ok) begin
          std_pat = PAT_ON;
        end else begin
          std_pat = PAT_OFF;
        end
      end

      // Overcurrent takes priority over detection failure
      always_comb begin
        if (overcurrent[p]) begin
          fault_pat = PAT_BLINK;
        end else if (detect_fail[p]) begin
          fault_pat = PAT_ON;
        end else begin
          fault_pat = PAT_OFF;
        end
      end

      assign hp_d    = pat_level(hp_pat, blink_q);
      assign std_d   = pat_level(std_pat, blink_q);
      assign fault_d = pat_level(fault_pat, blink_q);

      // Registered so the pins never glitch
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          led_poe_hp_q[p] <= 1'b0;
        end else begin
          led_poe_hp_q[p] <= hp_d;
        end
      end

      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          led_poe_std_q[p] <= 1'b0;
        end else begin
          led_poe_std_q[p] <= std_d;
        end
      end

      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          led_poe_fault_q[p] <= 1'b0;
        end else begin
          led_poe_fault_q[p] <= fault_d;
        end
      end
    end
  endgenerate

endmodule : pld_led_driver

/* test/pld_led_checker.sv */
`timescale 1ns/1ps
module pld_led_checker
  import pld_pkg::*;
#(
  parameter int unsigned NUM_PORTS = 1,
  parameter int unsigned NUM_POE   = 1,
  parameter int unsigned HALF_CYC  = 4
) (
  input wire logic                   core_clk,
  input wire logic                   reset,
  input wire logic [NUM_PORTS*2-1:0] port_kind,
  input wire logic [NUM_PORTS-1:0]   port_active,
  input wire logic [NUM_PORTS-1:0]   link_up,
  input wire logic [NUM_PORTS*3-1:0] link_speed,
  input wire logic [NUM_PORTS-1:0]   tx_active,
  input wire logic [NUM_POE*2-1:0]   pd_type,
  input wire logic [NUM_POE-1:0]     pd_dual_sig,
  input wire logic [NUM_POE*4-1:0]   pd_class,
  input wire logic [NUM_POE-1:0]     pd_powered,
  input wire logic [NUM_POE-1:0]     budget_shutoff,
  input wire logic [NUM_POE-1:0]     detect_fail,
  input wire logic [NUM_POE-1:0]     overcurrent,
  input wire logic [NUM_PORTS-1:0]   led_green_q,
  input wire logic [NUM_PORTS-1:0]   led_amber_q,
  input wire logic [NUM_POE-1:0]     led_poe_hp_q,
  input wire logic [NUM_POE-1:0]     led_poe_std_q,
  input wire logic [NUM_POE-1:0]     led_poe_fault_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire [3:0] c  = pd_class[3:0];
  wire [1:0] k  = port_kind[1:0];
  wire [2:0] s  = link_speed[2:0];
  wire       up = port_active[0] & link_up[0];
  wire       hp = pd_powered[0] & pd_type[1:0] == PD_BT &
    (pd_dual_sig[0] ? c >= DS_HP_MIN & c <= DS_HP_MAX : c >= SS_HP_MIN & c <= SS_HP_MAX);
  wire       sd = pd_powered[0] & pd_type[1:0] == PD_AFAT & !pd_dual_sig[0] & c <= SS_STD_MAX;
  wire       g  = up & ((k == KIND_COPPER | k == KIND_FIBRE_1G) & s == SPEED_1000 |
    k == KIND_FIBRE_25G & s == SPEED_2500);
  wire       a  = up & (k == KIND_COPPER & (s == SPEED_10 | s == SPEED_100) |
    k == KIND_FIBRE_1G & s == SPEED_100 | k == KIND_FIBRE_25G & s == SPEED_1000);
  hp_led_a: assert property (1 |=> led_poe_hp_q[0] == $past(hp))
    else $error("hp led mismatch");
  std_led_a: assert property (!budget_shutoff[0] |=> led_poe_std_q[0] == $past(sd))
    else $error("std led mismatch");
  std_blink_a: assert property (budget_shutoff[0] [*8] |->
    led_poe_std_q[0] != $past(led_poe_std_q[0], HALF_CYC)) else $error("std led not blinking");
  fault_led_a: assert property (!overcurrent[0] |=>
    led_poe_fault_q[0] == $past(detect_fail[0])) else $error("fault led mismatch");
  fault_blink_a: assert property (overcurrent[0] [*8] |->
    led_poe_fault_q[0] != $past(led_poe_fault_q[0], HALF_CYC)) else $error("fault led not blinking");
  green_led_a: assert property (!tx_active[0] |=> led_green_q[0] == $past(g))
    else $error("green led mismatch");
  amber_led_a: assert property (!tx_active[0] |=> led_amber_q[0] == $past(a))
    else $error("amber led mismatch");
  link_down_a: assert property (!up |=> !(led_green_q[0] | led_amber_q[0]))
    else $error("speed led lit with link down");
  tx_blink_a: assert property ((g & tx_active[0]) [*8] |->
    led_green_q[0] != $past(led_green_q[0], HALF_CYC)) else $error("tx blink");
endmodule : pld_led_checker

/* test/pld_led_panel.sv */
`timescale 1ns/1ps
module pld_led_panel (
  input  wire logic       core_clk,
  input  wire logic [1:0] led_on,
  output logic      [1:0] lit_cnt
);
  always_ff @(posedge core_clk) begin
    lit_cnt <= 2'($countones(led_on));
  end
endmodule : pld_led_panel

/* test/test_port_poe_status_led_driver.sv */
`timescale 1ns/1ps
module test_port_poe_status_led_driver;
  import pld_pkg::*;
  logic core_clk = 0, reset = 1, port_active = 0, link_up = 0, tx_active = 0, pd_dual_sig = 0;
  logic pd_powered = 0, budget_shutoff = 0, detect_fail = 0, overcurrent = 0;
  logic [1:0] port_kind = 0, pd_type = 0;
  logic [2:0] link_speed = 0;
  logic [3:0] pd_class = 0;
  logic led_green_q, led_amber_q, led_poe_hp_q, led_poe_std_q, led_poe_fault_q;
  logic [1:0] lit_cnt;
  int fails = 0, samples_checked = 0;
  always #5 core_clk = ~core_clk;
  pld_led_driver #(.NUM_PORTS(1), .NUM_POE(1), .HALF_CYC(4)) i_pld_led_driver (.*);
  pld_led_panel i_pld_led_panel (.core_clk, .led_on({led_green_q, led_amber_q}), .lit_cnt(lit_cnt));
  task automatic chk(string n, logic e, logic v);
    samples_checked++;
    if (v !== e) begin
      fails++;
      $display("ERROR %s expected %b seen %b", n, e, v);
    end
  endtask : chk
  task automatic t_poe;
    int lit;
    pd_powered = 1;
    for (int x = 0; x < 36; x++) begin
      int c;
      logic hp_e;
      c = x % 18 / 2;
      {pd_type, pd_dual_sig, pd_class} = {2'(x / 18 + 1), x % 2 == 1, 4'(c)};
      @(negedge core_clk);
      hp_e = pd_type == PD_BT && (pd_dual_sig ? c inside {[1:5]} : c inside {[5:8]});
      chk("hp", hp_e, led_poe_hp_q);
      chk("std", pd_type == PD_AFAT && !pd_dual_sig && c < 5, led_poe_std_q);
    end
    {budget_shutoff, detect_fail} = 2'h3;
    lit = 0;
    for (int i = 0; i < 12; i++) begin
      @(negedge core_clk);
      lit += led_poe_std_q;
    end
    chk("std blink", 1, lit inside {[4:8]});
    chk("fault", 1, led_poe_fault_q);
    overcurrent = 1;
    lit = 0;
    for (int i = 0; i < 12; i++) begin
      @(negedge core_clk);
      lit += led_poe_fault_q;
    end
    chk("fault blink", 1, lit inside {[4:8]});
    {pd_powered, budget_shutoff, detect_fail, overcurrent} = 4'h0;
    @(negedge core_clk);
    chk("off", 0, led_poe_hp_q | led_poe_fault_q);
    $display("test poe done");
  endtask : t_poe
  task automatic t_speed;
    int lit;
    {port_active, link_up} = 2'h3;
    for (int x = 0; x < 16; x++) begin
      {port_kind, link_speed} = {2'(x / 4), 3'(x % 4)};
      @(negedge core_clk);
      if (x != 3 && x != 4 && x != 7 && x != 8 && x != 9) begin
        chk("green", x == 2 || x == 6 || x == 11, led_green_q);
        chk("amber", x < 2 || x == 5 || x == 10, led_amber_q);
      end
    end
    {port_kind, link_speed} = {KIND_FIBRE_25G, SPEED_2500};
    repeat (2) @(negedge core_clk);
    chk("panel lit", 1, lit_cnt == 2'h1);
    tx_active = 1;
    lit = 0;
    for (int i = 0; i < 12; i++) begin
      @(negedge core_clk);
      lit += led_green_q;
    end
    chk("green blink", 1, lit inside {[4:8]});
    link_up = 0;
    @(negedge core_clk);
    chk("down", 0, led_green_q);
    @(negedge core_clk);
    chk("panel dark", 1, lit_cnt == 2'h0);
    $display("test speed done");
  endtask : t_speed
  task automatic results;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  initial begin
    repeat (2) @(negedge core_clk);
    reset = 0;
    t_poe();
    t_speed();
    results();
  end
endmodule : test_port_poe_status_led_driver
bind pld_led_driver pld_led_checker #(.NUM_PORTS(NUM_PORTS), .NUM_POE(NUM_POE),
  .HALF_CYC(HALF_CYC)) i_pld_led_checker (.*);
